// ---- hdl/rfs_regs.svh ----
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

// ---------------------------------------------------------------------------
// Clock and times
// ---------------------------------------------------------------------------
`define RFS_CLK_PERIOD_NS   100
`define RFS_STABLE_US       200
`define RFS_STABLE_CYC      ((`RFS_STABLE_US * 1000 + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_REF_PERIOD_MS   32
`define RFS_REF_TOTAL       65536
`define RFS_REF_AVG_NS      490
`define RFS_REF_AVG_CYC     (`RFS_REF_AVG_NS / `RFS_CLK_PERIOD_NS)
`define RFS_REF_BURST_NS    3900
`define RFS_REF_BURST_CYC   (`RFS_REF_BURST_NS / `RFS_CLK_PERIOD_NS)

// ---------------------------------------------------------------------------
// Counts and cycle figures
// ---------------------------------------------------------------------------
`define RFS_BANKS           8
`define RFS_DUMMY_MRS       2
`define RFS_INIT_NOPS       1024
`define RFS_DLL_LOCK_CYC    1024
`define RFS_TRC_CYC         4
`define RFS_MRSC_CYC        6
`define RFS_WR_RD_NOPS      2

// ---------------------------------------------------------------------------
// Mode word fields
// ---------------------------------------------------------------------------
`define RFS_LOOP_BIT        7
`define RFS_MODE_LOW_W      10

// ---------------------------------------------------------------------------
// Command encodings {cs_n, we_n, ref_n}
// ---------------------------------------------------------------------------
`define RFS_CMD_NOP         3'h7
`define RFS_CMD_MRS         3'h0
`define RFS_CMD_READ        3'h2
`define RFS_CMD_WRITE       3'h1
`define RFS_CMD_BANK_REFRESH_CMD        3'h3

`endif

// ---- hdl/rfs_pkg.sv ----
`default_nettype none

package rfs_pkg;

  // Command pin triple {cs_n, we_n, ref_n}
  typedef logic [2:0] rfs_cmd_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_STABLE,
    ST_DUMMY,
    ST_VALID,
    ST_RECOV,
    ST_INIT_REF,
    ST_PAD,
    ST_RUN,
    ST_DLL_OFF,
    ST_DLL_GAP,
    ST_DLL_ON
  } rfs_state_t;

endpackage

`default_nettype wire

// ---- hdl/rfs_bank_timer.sv ----
`include "rfs_regs.svh"
`default_nettype none

module rfs_bank_timer #(
  parameter int BANKS   = `RFS_BANKS,
  parameter int TRC_CYC = `RFS_TRC_CYC
) (
  input  wire logic                     clock_i,
  input  wire logic                     reset_i,
  input  wire logic                     fire_i,
  input  wire logic [$clog2(BANKS)-1:0] bank_i,
  output logic      [BANKS-1:0]         busy_o
);

  localparam int CW = $clog2(TRC_CYC + 1);

  // ---------------------------------------------------------------------------
  // One row-cycle counter per bank
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      logic [CW-1:0] cnt_r;

      always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
          cnt_r <= '0;
        end else if (fire_i && (bank_i == g)) begin
          cnt_r <= CW'(TRC_CYC - 1);
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - CW'(1);
        end
      end

      // Busy until the counter runs out
      assign busy_o[g] = (cnt_r != '0);
    end
  endgenerate

endmodule

`default_nettype wire

// ---- hdl/rfs_refresh_timer.sv ----
`include "rfs_regs.svh"
`default_nettype none

module rfs_refresh_timer #(
  parameter int AVG_CYC   = `RFS_REF_AVG_CYC,
  parameter int BURST_CYC = `RFS_REF_BURST_CYC,
  parameter int BANKS     = `RFS_BANKS
) (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       enable_i,
  input  wire logic       burst_mode_i,
  output logic            due_o,
  output logic [3:0]      due_count_o
);

  localparam int CW = $clog2(BURST_CYC + AVG_CYC + 1);

  logic [CW-1:0] cnt_r;

  // ---------------------------------------------------------------------------
  // Interval counter
  // ---------------------------------------------------------------------------
  // even spacing
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      due_o <= 1'b0;
    end else if (!enable_i) begin
      cnt_r <= '0;
      due_o <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= burst_mode_i ? CW'(BURST_CYC - 1) : CW'(AVG_CYC - 1);
      due_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r - CW'(1);
      due_o <= 1'b0;
    end
  end

  // Mode switch applies at the next reload
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      due_count_o <= 4'h1;
    end else if (enable_i && (cnt_r == '0)) begin
      due_count_o <= burst_mode_i ? 4'(BANKS) : 4'h1;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/rfs_sequencer.sv ----
`include "rfs_regs.svh"
`default_nettype none

// Behaviour
// - Bank select is driven with every bank refresh command.
// - No command to a bank within the row cycle time after its refresh.
// - Whole device refreshed each 32 ms, 64K commands, spacing at most 0.49 us.
// - Optionally eight refreshes, one per bank, every 3.9 us.
// - After power-up hold NOP conditions for at least 200 us.
// - Then two or more dummy mode-sets followed by one valid mode-set.
// - No recovery wait is needed between those initial mode-sets.
// - Dummy mode-sets drive every address line low.
// - Recovery time after valid mode-set, refresh all 8 banks with 1,024 NOPs.
// - Initial refreshes may sit anywhere among the NOPs.
// - Address bits A10 to A17 are low during initial mode-sets.
// - Clock or supply change requires a loop reset through mode-set.
// - Same-bank writes are spaced by the row cycle time.
// - Same-bank reads are spaced by the row cycle time.
// - Write followed by read gets enough NOP cycles, two by default.
// - Loop reset: bit low, wait recovery, bit high, 1,024 cycles before read.
module rfs_sequencer
  import rfs_pkg::*;
#(
  parameter int ADDR_W       = 18,
  parameter int BANKS        = `RFS_BANKS,
  parameter int STABLE_CYC   = `RFS_STABLE_CYC,
  parameter int DUMMY_MRS    = `RFS_DUMMY_MRS,
  parameter int MRSC_CYC     = `RFS_MRSC_CYC,
  parameter int TRC_CYC      = `RFS_TRC_CYC,
  parameter int INIT_NOPS    = `RFS_INIT_NOPS,
  parameter int DLL_LOCK_CYC = `RFS_DLL_LOCK_CYC,
  parameter int WR_RD_NOPS   = `RFS_WR_RD_NOPS,
  parameter int REF_AVG_CYC  = `RFS_REF_AVG_CYC,
  parameter int REF_BST_CYC  = `RFS_REF_BURST_CYC
) (
  input  wire logic                       clock_i,
  input  wire logic                       reset_i,
  input  wire logic                       dll_reset_req_i,
  input  wire logic                       burst_mode_i,
  input  wire logic [`RFS_MODE_LOW_W-1:0] mode_cfg_i,
  input  wire logic                       req_valid_i,
  input  wire logic                       req_write_i,
  input  wire logic [$clog2(BANKS)-1:0]   req_bank_i,
  input  wire logic [ADDR_W-1:0]          req_addr_i,
  output logic                            cs_n_o,
  output logic                            we_n_o,
  output logic                            ref_n_o,
  output logic      [$clog2(BANKS)-1:0]   ba_o,
  output logic      [ADDR_W-1:0]          addr_o,
  output logic                            req_ack_o,
  output logic                            init_done_o,
  output logic                            dll_locked_o
);

  localparam int BW = $clog2(BANKS);
  localparam int LW = $clog2(DLL_LOCK_CYC + 1);
  localparam int GW = $clog2(WR_RD_NOPS + 1);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  rfs_state_t      state_r;
  rfs_state_t      state_nxt;
  logic [15:0]     wait_r;
  logic [15:0]     wait_nxt;
  logic [BW:0]     step_r;
  logic [BW:0]     step_nxt;
  logic [5:0]      owed_r;
  logic [BW-1:0]   ref_bank_r;
  logic [GW-1:0]   wr_gap_r;
  logic [LW-1:0]   lock_r;
  logic [LW-1:0]   lock_nxt;
  logic            dll_req_r;
  rfs_cmd_t        cmd_nxt;
  logic [BW-1:0]   ba_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic            bank_fire;
  logic            ref_take;
  logic            user_take;
  logic            lock_load;
  logic            dll_start;
  logic            read_block;
  logic [BANKS-1:0] busy;
  logic            ref_due;
  logic [3:0]      ref_due_count;
  logic            ref_run;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Mode word: upper bits low, loop bit chosen
  function automatic logic [ADDR_W-1:0] mode_word(
    input logic [`RFS_MODE_LOW_W-1:0] cfg,
    input logic                       loop_on
  );
    logic [ADDR_W-1:0] w;
    w = '0;
    w[`RFS_MODE_LOW_W-1:0] = cfg;
    w[`RFS_LOOP_BIT] = loop_on;
    return w;
  endfunction

  // ---------------------------------------------------------------------------
  // Row cycle and refresh timers
  // ---------------------------------------------------------------------------
  rfs_bank_timer #(
    .BANKS   (BANKS),
    .TRC_CYC (TRC_CYC)
  ) u_bank_timer (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .fire_i  (bank_fire),
    .bank_i  (ba_nxt),
    .busy_o  (busy)
  );

  // Refresh scheduling starts once initialised
  assign ref_run = init_done_o;

  rfs_refresh_timer #(
    .AVG_CYC   (REF_AVG_CYC),
    .BURST_CYC (REF_BST_CYC),
    .BANKS     (BANKS)
  ) u_refresh_timer (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .enable_i     (ref_run),
    .burst_mode_i (burst_mode_i),
    .due_o        (ref_due),
    .due_count_o  (ref_due_count)
  );

  // Reads wait for loop lock and write turnaround
  assign read_block = (lock_r != '0) || (wr_gap_r != '0);

  // ---------------------------------------------------------------------------
  // Command decision
  // ---------------------------------------------------------------------------
  // init state machine
  always_comb begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    step_nxt  = step_r;
    cmd_nxt   = `RFS_CMD_NOP;
    ba_nxt    = '0;
    addr_nxt  = '0;
    bank_fire = 1'b0;
    ref_take  = 1'b0;
    user_take = 1'b0;
    lock_load = 1'b0;
    dll_start = 1'b0;
    unique case (state_r)
      ST_STABLE: begin
        if (wait_r == '0) begin
          state_nxt = ST_DUMMY;
          step_nxt  = '0;
        end else begin
          wait_nxt = wait_r - 16'h1;
        end
      end
      ST_DUMMY: begin
        cmd_nxt  = `RFS_CMD_MRS;
        step_nxt = step_r + (BW+1)'(1);
        if (step_r == (BW+1)'(DUMMY_MRS - 1)) begin
          state_nxt = ST_VALID;
        end
      end
      ST_VALID: begin
        cmd_nxt   = `RFS_CMD_MRS;
        addr_nxt  = mode_word(mode_cfg_i, 1'b1);
        lock_load = 1'b1;
        wait_nxt  = 16'(MRSC_CYC - 1);
        state_nxt = ST_RECOV;
      end
      ST_RECOV: begin
        if (wait_r == '0) begin
          state_nxt = ST_INIT_REF;
          step_nxt  = '0;
        end else begin
          wait_nxt = wait_r - 16'h1;
        end
      end
      ST_INIT_REF: begin
        cmd_nxt   = `RFS_CMD_BANK_REFRESH_CMD;
        ba_nxt    = step_r[BW-1:0];
        bank_fire = 1'b1;
        step_nxt  = step_r + (BW+1)'(1);
        if (step_r == (BW+1)'(BANKS - 1)) begin
          state_nxt = ST_PAD;
          wait_nxt  = 16'(INIT_NOPS - 1);
        end
      end
      ST_PAD: begin
        if (wait_r == '0) begin
          state_nxt = ST_RUN;
        end else begin
          wait_nxt = wait_r - 16'h1;
        end
      end
      ST_RUN: begin
        if (dll_req_r) begin
          dll_start = 1'b1;
          state_nxt = ST_DLL_OFF;
        end else if ((owed_r != '0) && !busy[ref_bank_r]) begin
          cmd_nxt   = `RFS_CMD_BANK_REFRESH_CMD;
          ba_nxt    = ref_bank_r;
          bank_fire = 1'b1;
          ref_take  = 1'b1;
        end else if (req_valid_i && !req_ack_o && !busy[req_bank_i] &&
                     (req_write_i || !read_block)) begin
          cmd_nxt   = req_write_i ? `RFS_CMD_WRITE : `RFS_CMD_READ;
          ba_nxt    = req_bank_i;
          addr_nxt  = req_addr_i;
          bank_fire = 1'b1;
          user_take = 1'b1;
        end
      end
      ST_DLL_OFF: begin
        cmd_nxt   = `RFS_CMD_MRS;
        addr_nxt  = mode_word(mode_cfg_i, 1'b0);
        wait_nxt  = 16'(MRSC_CYC - 1);
        state_nxt = ST_DLL_GAP;
      end
      ST_DLL_GAP: begin
        if (wait_r == '0) begin
          state_nxt = ST_DLL_ON;
        end else begin
          wait_nxt = wait_r - 16'h1;
        end
      end
      ST_DLL_ON: begin
        cmd_nxt   = `RFS_CMD_MRS;
        addr_nxt  = mode_word(mode_cfg_i, 1'b1);
        lock_load = 1'b1;
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_STABLE;
      wait_r  <= 16'(STABLE_CYC - 1);
      step_r  <= '0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      step_r  <= step_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Refresh debt
  // ---------------------------------------------------------------------------
  // New debt and a refresh in the same cycle both count
  // refresh debt
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      owed_r <= '0;
    end else begin
      owed_r <= owed_r + (ref_due ? 6'(ref_due_count) : 6'h0) - (ref_take ? 6'h1 : 6'h0);
    end
  end

  // Round-robin keeps all banks on one schedule
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ref_bank_r <= '0;
    end else if (ref_take) begin
      ref_bank_r <= ref_bank_r + BW'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Turnaround and loop lock
  // ---------------------------------------------------------------------------
  // write to read gap
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_gap_r <= '0;
    end else if (user_take && req_write_i) begin
      wr_gap_r <= GW'(WR_RD_NOPS);
    end else if (wr_gap_r != '0) begin
      wr_gap_r <= wr_gap_r - GW'(1);
    end
  end

  always_comb begin
    lock_nxt = lock_r;
    if (lock_load) begin
      lock_nxt = LW'(DLL_LOCK_CYC);
    end else if (lock_r != '0) begin
      lock_nxt = lock_r - LW'(1);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      lock_r       <= '0;
      dll_locked_o <= 1'b0;
    end else begin
      lock_r       <= lock_nxt;
      dll_locked_o <= (lock_nxt == '0) && (state_nxt != ST_DLL_OFF) &&
                      (state_nxt != ST_DLL_GAP) && (state_nxt != ST_DLL_ON) &&
                      init_done_o;
    end
  end

  // Set wins over clear, so a request during start is kept
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dll_req_r <= 1'b0;
    end else if (dll_reset_req_i) begin
      dll_req_r <= 1'b1;
    end else if (dll_start) begin
      dll_req_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin and user outputs
  // ---------------------------------------------------------------------------
  // Registered pins: command, bank and address move on one edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      {cs_n_o, we_n_o, ref_n_o} <= `RFS_CMD_NOP;
      ba_o                      <= '0;
      addr_o                    <= '0;
    end else begin
      {cs_n_o, we_n_o, ref_n_o} <= cmd_nxt;
      ba_o                      <= ba_nxt;
      addr_o                    <= addr_nxt;
    end
  end

  // Ack blocks a second take of a held request
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      req_ack_o <= 1'b0;
    end else begin
      req_ack_o <= user_take;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      init_done_o <= 1'b0;
    end else if (state_nxt == ST_RUN) begin
      init_done_o <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- bench/rfs_sequencer_properties.sv ----
`include "rfs_regs.svh"
`default_nettype none

// ---------------------------------------------
// Pin checker for the refresh and init sequencer
// ---------------------------------------------
module rfs_sequencer_properties #(
  parameter int STABLE_CYC   = 20,
  parameter int INIT_NOPS    = 16,
  parameter int DLL_LOCK_CYC = 8,
  parameter int TRC_CYC      = 4
) (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic [2:0]  req_bank_i,
  input wire logic        cs_n_o,
  input wire logic        we_n_o,
  input wire logic        ref_n_o,
  input wire logic [2:0]  ba_o,
  input wire logic [17:0] addr_o,
  input wire logic        req_ack_o,
  input wire logic        init_done_o,
  input wire logic        dll_locked_o
);
  logic [2:0]  cmd;
  logic        is_nop;
  logic        is_mrs;
  logic        is_rd;
  logic        is_wr;
  logic        is_ref;
  logic [3:0]  age_r [8];
  logic [15:0] since_rst_r;
  logic [15:0] nop_r;
  logic [15:0] lock_r;
  logic [7:0]  ref_mask_r;

  // Decode of the command pin triple
  assign cmd    = {cs_n_o, we_n_o, ref_n_o};
  assign is_nop = (cmd == `RFS_CMD_NOP);
  assign is_mrs = (cmd == `RFS_CMD_MRS);
  assign is_rd  = (cmd == `RFS_CMD_READ);
  assign is_wr  = (cmd == `RFS_CMD_WRITE);
  assign is_ref = (cmd == `RFS_CMD_BANK_REFRESH_CMD);

  // Per-bank cycles since last command, saturating
  always_ff @(posedge clock_i or posedge reset_i) begin
    for (int b = 0; b < 8; b++) begin
      if (reset_i) begin
        age_r[b] <= 4'hf;
      end else if ((is_rd || is_wr || is_ref) && ba_o == 3'(b)) begin
        age_r[b] <= 4'h0;
      end else if (age_r[b] != 4'hf) begin
        age_r[b] <= age_r[b] + 4'h1;
      end
    end
  end

  // Time since reset, NOPs since mode-set, banks refreshed
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      since_rst_r <= 16'h0;
      nop_r       <= 16'h0;
      ref_mask_r  <= 8'h00;
    end else begin
      if (since_rst_r != 16'hffff) begin
        since_rst_r <= since_rst_r + 16'h1;
      end
      if (is_mrs) begin
        nop_r <= 16'h0;
      end else if (is_nop && nop_r != 16'hffff) begin
        nop_r <= nop_r + 16'h1;
      end
      if (is_ref && !init_done_o) begin
        ref_mask_r <= ref_mask_r | (8'h01 << ba_o);
      end
    end
  end

  // Cycles since loop bit went high
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      lock_r <= 16'hffff;
    end else if (is_mrs && addr_o[7]) begin
      lock_r <= 16'h0;
    end else if (lock_r != 16'hffff) begin
      lock_r <= lock_r + 16'h1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence dummy_pair_s;
    is_mrs && addr_o == 18'h0 ##1 is_mrs && addr_o == 18'h0;
  endsequence

  sequence valid_set_s;
    is_mrs && addr_o[17:10] == 8'h00 && addr_o[7];
  endsequence

  stable_wait_a: assert property (
    !is_nop |-> since_rst_r >= 16'(STABLE_CYC)) else $error("command before stable wait");
  init_mode_a: assert property (
    $rose(is_mrs) && !init_done_o |-> dummy_pair_s ##1 valid_set_s)
    else $error("init mode-set order wrong");
  mrsc_gap_a: assert property (
    (valid_set_s and !init_done_o) |=> is_nop [*6]) else $error("no recovery after mode-set");
  init_refresh_a: assert property (
    $rose(init_done_o) |-> ref_mask_r == 8'hff && nop_r >= 16'(INIT_NOPS))
    else $error("ready before init refreshes");
  bank_cycle_a: assert property (
    (is_rd || is_wr || is_ref) |-> age_r[ba_o] >= 4'(TRC_CYC - 1))
    else $error("row cycle time broken");
  wr_rd_turn_a: assert property (
    is_rd |-> !$past(is_wr) && !$past(is_wr, 2)) else $error("read too soon after write");
  lock_wait_a: assert property (
    is_rd |-> lock_r >= 16'(DLL_LOCK_CYC)) else $error("read during lock wait");
  loop_reset_a: assert property (
    is_mrs && init_done_o && !addr_o[7] |=> is_nop [*6] ##1 (is_mrs && addr_o[7]))
    else $error("loop reset sequence wrong");
  refresh_gap_a: assert property (
    init_done_o && dll_locked_o |-> ##[0:48] is_ref) else $error("refresh starved");
  ack_cmd_a: assert property (
    req_ack_o |-> (is_rd || is_wr) && ba_o == $past(req_bank_i))
    else $error("ack without user command");
endmodule

bind rfs_sequencer rfs_sequencer_properties #(
  .STABLE_CYC   (STABLE_CYC),
  .INIT_NOPS    (INIT_NOPS),
  .DLL_LOCK_CYC (DLL_LOCK_CYC),
  .TRC_CYC      (TRC_CYC)
) chk_u (
  .clock_i      (clock_i),
  .reset_i      (reset_i),
  .req_bank_i   (req_bank_i),
  .cs_n_o       (cs_n_o),
  .we_n_o       (we_n_o),
  .ref_n_o      (ref_n_o),
  .ba_o         (ba_o),
  .addr_o       (addr_o),
  .req_ack_o    (req_ack_o),
  .init_done_o  (init_done_o),
  .dll_locked_o (dll_locked_o)
);

`default_nettype wire

// ---- bench/rfs_mem_model.sv ----
`include "rfs_regs.svh"
`default_nettype none

// Memory device model at the command pins
module rfs_mem_model #(
  parameter int TRC_CYC    = 4,
  parameter int WR_RD_NOPS = 2
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        cs_n_i,
  input  wire logic        we_n_i,
  input  wire logic        ref_n_i,
  input  wire logic [2:0]  ba_i,
  input  wire logic [17:0] addr_i,
  output logic      [15:0] cyc_o,
  output logic      [15:0] ref_total_o,
  output logic      [15:0] mrs_total_o,
  output logic      [15:0] viol_o,
  output logic      [15:0] mrs_lo_o,
  output logic      [15:0] mrs_hi_o
);
  logic [2:0]  cmd;
  logic [12:0] row_r [8];
  logic [15:0] last_r [8];
  logic [15:0] wr_at_r;

  assign cmd = {cs_n_i, we_n_i, ref_n_i};

  // Cycle stamp
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_o <= 16'h0;
    end else begin
      cyc_o <= cyc_o + 16'h1;
    end
  end

  // bank row refresh
  // Row from the bank's own counter, address pins ignored
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      row_r       <= '{default: '0};
      ref_total_o <= 16'h0;
    end else if (cmd == `RFS_CMD_BANK_REFRESH_CMD) begin
      row_r[ba_i] <= row_r[ba_i] + 13'h1;
      ref_total_o <= ref_total_o + 16'h1;
    end
  end

  // mode-set record
  // Loop bit edges stamped to measure the lock wait
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mrs_total_o <= 16'h0;
      mrs_lo_o    <= 16'h0;
      mrs_hi_o    <= 16'h0;
    end else if (cmd == `RFS_CMD_MRS) begin
      mrs_total_o <= mrs_total_o + 16'h1;
      if (addr_i[7]) begin
        mrs_hi_o <= cyc_o;
      end else begin
        mrs_lo_o <= cyc_o;
      end
    end
  end

  // bank timing guard
  // A real part would lose data, so breaches are counted
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      last_r  <= '{default: '0};
      wr_at_r <= 16'h0;
      viol_o  <= 16'h0;
    end else if (cmd == `RFS_CMD_BANK_REFRESH_CMD || cmd == `RFS_CMD_READ || cmd == `RFS_CMD_WRITE) begin
      if (cyc_o - last_r[ba_i] < 16'(TRC_CYC)) begin
        viol_o <= viol_o + 16'h1;
      end
      if (cmd == `RFS_CMD_READ && cyc_o - wr_at_r <= 16'(WR_RD_NOPS)) begin
        viol_o <= viol_o + 16'h1;
      end
      if (cmd == `RFS_CMD_WRITE) begin
        wr_at_r <= cyc_o;
      end
      last_r[ba_i] <= cyc_o;
    end
  end
endmodule

`default_nettype wire

// ---- bench/test_dram_refresh_init_sequencer.sv ----
`include "rfs_regs.svh"
`default_nettype none

`define CHK(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("CHECK FAILED %0t %s", $time, msg); \
    end \
  end

module test_dram_refresh_init_sequencer;
  timeunit 1ns;
  timeprecision 1ns;

  // Shortened counts keep the run brief
  localparam int STABLE = 20;
  localparam int NOPS   = 16;
  localparam int LOCK   = 8;

  logic        clock;
  logic        reset;
  logic        dll_req;
  logic        burst;
  logic        valid;
  logic        write;
  logic [2:0]  bank;
  logic [17:0] addr_in;
  logic        cs_n;
  logic        we_n;
  logic        ref_n;
  logic [2:0]  ba;
  logic [17:0] addr;
  logic        ack;
  logic        done;
  logic        locked;
  logic [15:0] cyc;
  logic [15:0] ref_total;
  logic [15:0] mrs_total;
  logic [15:0] viol;
  logic [15:0] mrs_lo;
  logic [15:0] mrs_hi;
  int          mismatches;
  int          check_count;

  rfs_sequencer #(.STABLE_CYC(STABLE), .INIT_NOPS(NOPS), .DLL_LOCK_CYC(LOCK)) dut_u (
    .clock_i(clock), .reset_i(reset), .dll_reset_req_i(dll_req), .burst_mode_i(burst),
    .mode_cfg_i(10'h155), .req_valid_i(valid), .req_write_i(write), .req_bank_i(bank),
    .req_addr_i(addr_in), .cs_n_o(cs_n), .we_n_o(we_n), .ref_n_o(ref_n), .ba_o(ba),
    .addr_o(addr), .req_ack_o(ack), .init_done_o(done), .dll_locked_o(locked));

  rfs_mem_model mem_u (
    .clock_i(clock), .reset_i(reset), .cs_n_i(cs_n), .we_n_i(we_n), .ref_n_i(ref_n),
    .ba_i(ba), .addr_i(addr), .cyc_o(cyc), .ref_total_o(ref_total),
    .mrs_total_o(mrs_total), .viol_o(viol), .mrs_lo_o(mrs_lo), .mrs_hi_o(mrs_hi));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One user command held until ack; pins judged in the ack cycle
  task automatic issue(input logic w, input logic [2:0] b, input logic [17:0] a,
                       output logic [15:0] at);
    valid   = 1'b1;
    write   = w;
    bank    = b;
    addr_in = a;
    repeat (300) begin
      step(1);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      `CHK(ack, 1'b1, "no acknowledge")
      report_and_stop();
    end
    `CHK({cs_n, we_n, ref_n}, w ? `RFS_CMD_WRITE : `RFS_CMD_READ, "command code")
    `CHK({ba, addr}, {b, a}, "bank and address")
    at = cyc;
  endtask

  // Reset pins, then power-up up to ready
  task automatic chk_init;
    int n;
    `CHK({cs_n, we_n, ref_n, ack, done}, {`RFS_CMD_NOP, 2'b00}, "pins in reset")
    reset = 1'b0;
    for (n = 1; n <= 500; n++) begin
      step(1);
      if (done === 1'b1) break;
    end
    `CHK(n >= STABLE + 3 + `RFS_MRSC_CYC + 8 + NOPS && n <= 500, 1'b1, "ready too early")
    `CHK(mrs_total, 16'd3, "mode-sets")
    `CHK(ref_total, 16'd8, "refreshes")
  endtask

  // Back-to-back command pairs
  task automatic chk_pairs;
    logic [15:0] t1;
    logic [15:0] t2;
    int          tab [4][5] = '{'{1, 2, 0, 2, 4}, '{1, 3, 0, 4, 3},
                                '{0, 6, 0, 6, 4}, '{1, 1, 1, 1, 4}};
    for (int i = 0; i < 4; i++) begin
      issue(tab[i][0][0], tab[i][1][2:0], 18'h2a5a5 ^ 18'(i), t1);
      issue(tab[i][2][0], tab[i][3][2:0], 18'h15a5a ^ 18'(i), t2);
      valid = 1'b0;
      `CHK(t2 - t1 >= 16'(tab[i][4]), 1'b1, "pair spacing")
      step(1);
    end
  endtask

  // Refresh rate, even then grouped
  task automatic chk_refresh;
    logic [15:0] r0;
    r0 = ref_total;
    step(400);
    `CHK(ref_total - r0 >= 16'd98 && ref_total - r0 <= 16'd102, 1'b1, "even rate")
    burst = 1'b1;
    r0    = ref_total;
    step(390);
    `CHK(ref_total - r0 >= 16'd72 && ref_total - r0 <= 16'd88, 1'b1, "group rate")
    burst = 1'b0;
    step(40);
  endtask

  // Loop reset, read waiting
  task automatic chk_dll;
    logic [15:0] t;
    dll_req = 1'b1;
    step(1);
    dll_req = 1'b0;
    issue(1'b0, 3'h0, 18'h00f0f, t);
    valid = 1'b0;
    `CHK(mrs_lo > 16'd100, 1'b1, "no loop off")
    `CHK(mrs_hi - mrs_lo, 16'(`RFS_MRSC_CYC + 1), "loop off to on gap")
    `CHK(t - mrs_hi >= 16'(LOCK + 1), 1'b1, "lock wait")
    step(2);
    `CHK(locked, 1'b1, "lock flag")
  endtask

  initial begin
    reset       = 1'b1;
    dll_req     = 1'b0;
    burst       = 1'b0;
    valid       = 1'b0;
    write       = 1'b0;
    bank        = 3'h0;
    addr_in     = 18'h0;
    mismatches  = 0;
    check_count = 0;
    step(16);
    chk_init();
    chk_pairs();
    chk_refresh();
    chk_dll();
    `CHK(viol, 16'd0, "device timing")
    report_and_stop();
  end
endmodule

`default_nettype wire
